// ### hdl/wdpfs_defs.svh
// wdpfs_defs.svh: offsets, bit positions, reset values and counts
// assumes an 8-bit special function register space and a crystal clock
`ifndef WDPFS_DEFS_SVH
`define WDPFS_DEFS_SVH

// ----------------------------------------------------------------
// register offsets and timed-access keys
// ----------------------------------------------------------------
`define WDPFS_CLKCTL_ADDR 8'h8E
`define WDPFS_WDCTL_ADDR 8'hD8
`define WDPFS_XIE_ADDR 8'hE8
`define WDPFS_TA_ADDR 8'hC7
`define WDPFS_TA_KEY1 8'hAA
`define WDPFS_TA_KEY2 8'h55

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WDPFS_SEL_HI_BIT 7
`define WDPFS_SEL_LO_BIT 6
`define WDPFS_PF_IRQ_EN_BIT 5
`define WDPFS_PF_FLAG_BIT 4
`define WDPFS_EARLY_FLAG_BIT 3
`define WDPFS_CAUSE_FLAG_BIT 2
`define WDPFS_WD_EN_BIT 1
`define WDPFS_RESTART_BIT 0
`define WDPFS_WD_IRQ_EN_BIT 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define WDPFS_CLKCTL_RST 8'h01
`define WDPFS_WDCTL_RST 8'h00
`define WDPFS_XIE_RST 8'h00

// ----------------------------------------------------------------
// timing counts, in crystal clocks
// ----------------------------------------------------------------
`define WDPFS_WD_INT0 27'h0020000
`define WDPFS_WD_INT1 27'h0100000
`define WDPFS_WD_INT2 27'h0800000
`define WDPFS_WD_INT3 27'h4000000
`define WDPFS_WD_TAIL 27'h0000200
`define WDPFS_POR_CLKS 17'h10000
`define WDPFS_WD_RST_CLKS 4'h4

// ----------------------------------------------------------------
// interrupt vectors
// ----------------------------------------------------------------
`define WDPFS_PF_VEC 8'h33
`define WDPFS_WDI_VEC 8'h63

`endif

// ### hdl/wdpfs_pkg.sv
// wdpfs_pkg: types shared by the supervisor block
// assumes wdpfs_defs.svh supplies the numeric constants
`default_nettype none

package wdpfs_pkg;

   // ----------------------------------------------------------------
   // register bus request
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } wdpfs_sfr_req_s;

   // ----------------------------------------------------------------
   // state enumerations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {POR_HOLD, POR_COUNT, POR_RUN} wdpfs_por_e;
   typedef enum logic [1:0] {WD_COUNT, WD_FINAL} wdpfs_wd_e;
   typedef enum logic [1:0] {TA_LOCKED, TA_KEY1, TA_OPEN} wdpfs_ta_e;

endpackage : wdpfs_pkg

`default_nettype wire

// ### hdl/wdpfs_top.sv
// wdpfs_top: watchdog, power-on/power-fail reset and power-fail warning
// assumes clk_sys is the crystal clock and the cpu drives one sfr access
// per cycle; supply comparator outputs are asynchronous
//
// Operation
// (RULE1) watchdog interval 2^17/2^20/2^23/2^26 by select
// (RULE2) early interrupt, then reset 512 clocks later
// (RULE3) early flag set with 512 clocks left
// (RULE4) reset flag marks a watchdog-caused reset
// (RULE5) enable bit turns the watchdog on
// (RULE6) restart bit begins a full new interval
// (RULE7) enable and restart need timed-access unlock first
// (RULE8) software unlocks with 0AAh then 55h at C7h
// (RULE9) watchdog request gated by its interrupt enable
// (RULE10) period select sits in bits 7 and 6
// (RULE11) controls at 8Eh, D8h and E8h
// (RULE12) software restarts before changing period select
// (RULE13) watchdog interrupt is a periodic idle wake
// (RULE14) power-up: hold, then 65536 clocks, then release
// (RULE15) supply below threshold holds reset throughout
// (RULE16) power-fail vector 0033h, highest priority
// (RULE17) bit 5 enables power-fail interrupt
// (RULE18) power-fail flag sticky until software clears
// (RULE19) reset clears count; restart drops pending phase
`timescale 1ns/1ps
`default_nettype none
`include "wdpfs_defs.svh"

module wdpfs_top
   import wdpfs_pkg::*;
#(
   parameter logic [26:0] WD_INT0 = `WDPFS_WD_INT0,
   parameter logic [26:0] WD_INT1 = `WDPFS_WD_INT1,
   parameter logic [26:0] WD_INT2 = `WDPFS_WD_INT2,
   parameter logic [26:0] WD_INT3 = `WDPFS_WD_INT3,
   parameter logic [16:0] POR_CLKS = `WDPFS_POR_CLKS
)
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire wdpfs_sfr_req_s sfr_req,
   input wire logic supply_below_reset,
   input wire logic supply_below_warning,
   output logic [7:0] sfr_rdata_r,
   output logic cpu_reset_r,
   output logic wdog_irq_req_r,
   output logic power_fail_warning_irq_r,
   output logic [7:0] irq_vector_r,
   output logic idle_wake_r
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic rst_meta_r;
   logic rst_sync_r;
   logic warn_meta_r;
   logic warn_sync_r;
   logic warn_dly_r;
   logic warn_rise;
   logic blk_rst;
   logic pwr_rst;
   wdpfs_por_e por_st_r;
   logic [16:0] por_cnt_r;
   wdpfs_ta_e ta_st_r;
   logic ta_open;
   logic [7:0] clkctl_r;
   logic [7:0] xie_r;
   logic [1:0] wdctl_spare_r;
   logic pf_irq_en_r;
   logic pf_flag_r;
   logic early_flag_r;
   logic cause_flag_r;
   logic wd_en_r;
   logic wr_clkctl;
   logic wr_wdctl;
   logic wr_xie;
   logic restart;
   wdpfs_wd_e wd_st_r;
   logic [26:0] wd_cnt_r;
   logic [26:0] wd_intv;
   logic early_evt;
   logic wd_fire;
   logic [3:0] wd_rst_cnt_r;
   logic wd_rst_act;
   logic [7:0] rd_val;
   logic wdog_irq_nxt;
   logic pf_irq_nxt;

   // ----------------------------------------------------------------
   // supply comparator synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= 1'b1;
      end
      else
      begin
         rst_meta_r <= supply_below_reset;
         rst_sync_r <= rst_meta_r;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         warn_meta_r <= 1'b0;
         warn_sync_r <= 1'b0;
         warn_dly_r <= 1'b0;
      end
      else
      begin
         warn_meta_r <= supply_below_warning;
         warn_sync_r <= warn_meta_r;
         warn_dly_r <= warn_sync_r;
      end
   end

   assign warn_rise = warn_sync_r & ~warn_dly_r;

   // ----------------------------------------------------------------
   // power-on and power-fail reset sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         por_st_r <= POR_HOLD;
         por_cnt_r <= 17'h00000;
      end
      else
      begin
         case (por_st_r)
            POR_HOLD:
            begin
               por_cnt_r <= 17'h00000;
               if (!rst_sync_r)
                  por_st_r <= POR_COUNT; // [RULE14]
            end
            POR_COUNT:
            begin
               if (rst_sync_r)
                  por_st_r <= POR_HOLD; // [RULE15]
               else if (por_cnt_r == POR_CLKS - 17'h00001)
                  por_st_r <= POR_RUN; // [RULE14]
               else
                  por_cnt_r <= por_cnt_r + 17'h00001;
            end
            POR_RUN:
            begin
               por_cnt_r <= 17'h00000;
               if (rst_sync_r)
                  por_st_r <= POR_HOLD; // [RULE15]
            end
            default:
               por_st_r <= POR_HOLD;
         endcase
      end
   end

   assign pwr_rst = srst | (por_st_r != POR_RUN);

   // ----------------------------------------------------------------
   // watchdog reset stretcher
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (pwr_rst)
         wd_rst_cnt_r <= 4'h0;
      else if (wd_fire)
         wd_rst_cnt_r <= `WDPFS_WD_RST_CLKS; // [RULE2]
      else if (wd_rst_cnt_r != 4'h0)
         wd_rst_cnt_r <= wd_rst_cnt_r - 4'h1;
   end

   assign wd_rst_act = (wd_rst_cnt_r != 4'h0);

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         cpu_reset_r <= 1'b1;
      else
         cpu_reset_r <= (por_st_r != POR_RUN) | wd_rst_act; // [RULE15]
   end

   assign blk_rst = srst | cpu_reset_r | wd_rst_act;

   // ----------------------------------------------------------------
   // timed access unlock
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
         ta_st_r <= TA_LOCKED;
      else if (sfr_req.wr)
      begin
         if (sfr_req.addr == `WDPFS_TA_ADDR && sfr_req.wdata == `WDPFS_TA_KEY1)
            ta_st_r <= TA_KEY1; // [RULE8]
         else if (ta_st_r == TA_KEY1 && sfr_req.addr == `WDPFS_TA_ADDR
                  && sfr_req.wdata == `WDPFS_TA_KEY2)
            ta_st_r <= TA_OPEN; // [RULE8]
         else
            ta_st_r <= TA_LOCKED; // [RULE7]
      end
   end

   assign ta_open = (ta_st_r == TA_OPEN);

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   assign wr_clkctl = sfr_req.wr && sfr_req.addr == `WDPFS_CLKCTL_ADDR; // [RULE11]
   assign wr_wdctl = sfr_req.wr && sfr_req.addr == `WDPFS_WDCTL_ADDR; // [RULE11]
   assign wr_xie = sfr_req.wr && sfr_req.addr == `WDPFS_XIE_ADDR; // [RULE11]
   assign restart = wr_wdctl && ta_open && sfr_req.wdata[`WDPFS_RESTART_BIT]; // [RULE7]

   // ----------------------------------------------------------------
   // clock control and extended interrupt enable
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
         clkctl_r <= `WDPFS_CLKCTL_RST;
      else if (wr_clkctl)
         clkctl_r <= sfr_req.wdata; // [RULE10]
   end

   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
         xie_r <= `WDPFS_XIE_RST;
      else if (wr_xie)
         xie_r <= sfr_req.wdata; // [RULE9]
   end

   // ----------------------------------------------------------------
   // watchdog control fields
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
      begin
         wdctl_spare_r <= 2'h0;
         pf_irq_en_r <= 1'b0;
      end
      else if (wr_wdctl)
      begin
         wdctl_spare_r <= sfr_req.wdata[7:6];
         pf_irq_en_r <= sfr_req.wdata[`WDPFS_PF_IRQ_EN_BIT]; // [RULE17]
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
         wd_en_r <= 1'b0;
      else if (wr_wdctl && ta_open)
         wd_en_r <= sfr_req.wdata[`WDPFS_WD_EN_BIT]; // [RULE5] [RULE7]
   end

   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
         pf_flag_r <= 1'b0;
      else if (warn_rise)
         pf_flag_r <= 1'b1; // [RULE18]
      else if (wr_wdctl && !sfr_req.wdata[`WDPFS_PF_FLAG_BIT])
         pf_flag_r <= 1'b0; // [RULE18]
   end

   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
         early_flag_r <= 1'b0;
      else if (early_evt)
         early_flag_r <= 1'b1; // [RULE3]
      else if (wr_wdctl && !sfr_req.wdata[`WDPFS_EARLY_FLAG_BIT])
         early_flag_r <= 1'b0;
   end

   always_ff @(posedge clk_sys)
   begin
      if (pwr_rst)
         cause_flag_r <= 1'b0;
      else if (wd_fire)
         cause_flag_r <= 1'b1; // [RULE4]
      else if (wr_wdctl && !cpu_reset_r && !sfr_req.wdata[`WDPFS_CAUSE_FLAG_BIT])
         cause_flag_r <= 1'b0;
   end

   // ----------------------------------------------------------------
   // watchdog counter
   // ----------------------------------------------------------------
   always_comb
   begin
      case (clkctl_r[`WDPFS_SEL_HI_BIT:`WDPFS_SEL_LO_BIT]) // [RULE10]
         2'b00: wd_intv = WD_INT0; // [RULE1]
         2'b01: wd_intv = WD_INT1; // [RULE1]
         2'b10: wd_intv = WD_INT2; // [RULE1]
         2'b11: wd_intv = WD_INT3; // [RULE1]
         default: wd_intv = WD_INT0;
      endcase
   end

   assign early_evt = wd_en_r && !restart && wd_st_r == WD_COUNT
                      && wd_cnt_r >= wd_intv - 27'h0000001; // [RULE2] [RULE3]
   assign wd_fire = wd_en_r && !restart && wd_st_r == WD_FINAL
                    && wd_cnt_r == `WDPFS_WD_TAIL - 27'h0000001; // [RULE2]

   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
      begin
         wd_st_r <= WD_COUNT; // [RULE19]
         wd_cnt_r <= 27'h0000000;
      end
      else if (restart || !wd_en_r)
      begin
         wd_st_r <= WD_COUNT; // [RULE6] [RULE19]
         wd_cnt_r <= 27'h0000000;
      end
      else
      begin
         case (wd_st_r)
            WD_COUNT:
            begin
               if (early_evt)
               begin
                  wd_st_r <= WD_FINAL; // [RULE2]
                  wd_cnt_r <= 27'h0000000;
               end
               else
                  wd_cnt_r <= wd_cnt_r + 27'h0000001; // [RULE1]
            end
            WD_FINAL:
            begin
               if (wd_fire)
               begin
                  wd_st_r <= WD_COUNT;
                  wd_cnt_r <= 27'h0000000;
               end
               else
                  wd_cnt_r <= wd_cnt_r + 27'h0000001; // [RULE2]
            end
            default:
            begin
               wd_st_r <= WD_COUNT;
               wd_cnt_r <= 27'h0000000;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   always_comb
   begin
      case (sfr_req.addr)
         `WDPFS_CLKCTL_ADDR: rd_val = clkctl_r;
         `WDPFS_WDCTL_ADDR: rd_val = {wdctl_spare_r, pf_irq_en_r, pf_flag_r,
                                      early_flag_r, cause_flag_r, wd_en_r, 1'b0};
         `WDPFS_XIE_ADDR: rd_val = xie_r;
         default: rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         sfr_rdata_r <= 8'h00;
      else if (sfr_req.rd)
         sfr_rdata_r <= rd_val;
   end

   // ----------------------------------------------------------------
   // interrupt requests
   // ----------------------------------------------------------------
   assign wdog_irq_nxt = early_flag_r & xie_r[`WDPFS_WD_IRQ_EN_BIT]; // [RULE9]
   assign pf_irq_nxt = pf_flag_r & pf_irq_en_r; // [RULE16] [RULE17]

   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
      begin
         wdog_irq_req_r <= 1'b0;
         power_fail_warning_irq_r <= 1'b0;
      end
      else
      begin
         wdog_irq_req_r <= wdog_irq_nxt; // [RULE9]
         power_fail_warning_irq_r <= pf_irq_nxt; // [RULE16]
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
         irq_vector_r <= 8'h00;
      else if (pf_irq_nxt)
         irq_vector_r <= `WDPFS_PF_VEC; // [RULE16]
      else if (wdog_irq_nxt)
         irq_vector_r <= `WDPFS_WDI_VEC;
      else
         irq_vector_r <= 8'h00;
   end

   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
         idle_wake_r <= 1'b0;
      else
         idle_wake_r <= wdog_irq_nxt | pf_irq_nxt; // [RULE13]
   end

endmodule : wdpfs_top

`default_nettype wire

// ### sim/wdpfs_top_sva.sv
// wdpfs_top_sva: port-level checks for the supervisor block
// assumes wdpfs_pkg is compiled first; bound to every wdpfs_top
`timescale 1ns/1ps
`default_nettype none

module wdpfs_top_sva
   import wdpfs_pkg::*;
#(
   parameter logic [16:0] POR_CLKS = 17'h10000
)
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire wdpfs_sfr_req_s sfr_req,
   input wire logic supply_below_reset,
   input wire logic [7:0] sfr_rdata_r,
   input wire logic cpu_reset_r,
   input wire logic wdog_irq_req_r,
   input wire logic power_fail_warning_irq_r,
   input wire logic [7:0] irq_vector_r,
   input wire logic idle_wake_r
);
   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);

   // length of the current reset pulse
   logic [17:0] hi_cnt_r;
   always_ff @(posedge clk_sys)
   begin
      if (srst || !cpu_reset_r)
         hi_cnt_r <= 18'h0;
      else if (hi_cnt_r != 18'h3FFFF)
         hi_cnt_r <= hi_cnt_r + 18'h1;
   end

   sequence s_pf_on;
      power_fail_warning_irq_r ##1 power_fail_warning_irq_r;
   endsequence
   sequence s_wd_only;
      (wdog_irq_req_r && !power_fail_warning_irq_r)[*2];
   endsequence
   sequence s_quiet;
      (!wdog_irq_req_r && !power_fail_warning_irq_r)[*2];
   endsequence

   chk_srst_state: assert property ($fell(srst) |-> cpu_reset_r && !wdog_irq_req_r)
      else $error("reset state wrong after srst");
   chk_supply_hold: assert property (supply_below_reset[*5] |-> cpu_reset_r)
      else $error("low supply without cpu reset");
   chk_pulse_min: assert property ($rose(cpu_reset_r) |-> cpu_reset_r[*4])
      else $error("cpu reset pulse too short");
   chk_reset_len: assert property ($fell(cpu_reset_r) |->
      (hi_cnt_r == 18'h4 || hi_cnt_r >= {1'b0, POR_CLKS}))
      else $error("cpu reset length wrong");
   chk_vec_pf: assert property (s_pf_on |-> irq_vector_r == 8'h33 && idle_wake_r)
      else $error("power-fail vector wrong");
   chk_vec_wd: assert property (s_wd_only |-> irq_vector_r == 8'h63 && idle_wake_r)
      else $error("watchdog vector wrong");
   chk_vec_none: assert property (s_quiet |-> irq_vector_r == 8'h00 && !idle_wake_r)
      else $error("vector without request");
   chk_quiet_reset: assert property (cpu_reset_r[*4] |->
      !wdog_irq_req_r && !power_fail_warning_irq_r)
      else $error("request during reset");
   chk_rdata_hold: assert property (!$past(sfr_req.rd) && !$past(sfr_req.rd, 2) &&
      !$past(srst) && !$past(cpu_reset_r) && !cpu_reset_r |-> $stable(sfr_rdata_r))
      else $error("read data moved without read");
endmodule : wdpfs_top_sva

bind wdpfs_top wdpfs_top_sva #(.POR_CLKS(POR_CLKS)) u_sva (.clk_sys(clk_sys), .srst(srst),
   .sfr_req(sfr_req), .supply_below_reset(supply_below_reset), .sfr_rdata_r(sfr_rdata_r),
   .cpu_reset_r(cpu_reset_r), .wdog_irq_req_r(wdog_irq_req_r),
   .power_fail_warning_irq_r(power_fail_warning_irq_r), .irq_vector_r(irq_vector_r),
   .idle_wake_r(idle_wake_r));

`default_nettype wire

// ### sim/wdpfs_top_tb_top.sv
// wdpfs_top_tb_top: directed bench for the supervisor block
// assumes package and checker compiled first; shortened counts
`timescale 1ns/1ps
`default_nettype none

module wdpfs_top_tb_top
   import wdpfs_pkg::*;
;
   // ---------------------------------------------
   // signals
   // ---------------------------------------------
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   wdpfs_sfr_req_s req = '0;
   logic sup_rst = 1'b0;
   logic sup_warn = 1'b0;
   logic [7:0] rdata, vec;
   logic cpu_rst, wd_irq, pf_irq, wake;
   int failures = 0;
   int check_count = 0;

   always #10 clk_sys = ~clk_sys;

   wdpfs_top #(.WD_INT0(27'h40), .WD_INT1(27'h80), .WD_INT2(27'hC0), .WD_INT3(27'h100),
      .POR_CLKS(17'h10)) DUT (.clk_sys(clk_sys), .srst(srst), .sfr_req(req),
      .supply_below_reset(sup_rst), .supply_below_warning(sup_warn), .sfr_rdata_r(rdata),
      .cpu_reset_r(cpu_rst), .wdog_irq_req_r(wd_irq), .power_fail_warning_irq_r(pf_irq),
      .irq_vector_r(vec), .idle_wake_r(wake));

   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk

   task automatic cyc(input int k);
      repeat (k) @(negedge clk_sys);
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk_sys);
      req = '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
   endtask : wr

   task automatic idle();
      @(negedge clk_sys);
      req = '0;
   endtask : idle

   task automatic chkrd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(negedge clk_sys);
      req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      idle();
      @(negedge clk_sys);
      chk(what, rdata, exp);
   endtask : chkrd

   task automatic ul();
      wr(8'hC7, 8'hAA);
      wr(8'hC7, 8'h55);
   endtask : ul

   task automatic wait_lvl(ref logic s, input logic v, input int lim, output int k);
      k = 0;
      while (s !== v && k < lim)
      begin
         @(negedge clk_sys);
         k++;
      end
   endtask : wait_lvl

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_por();
      int k;
      cyc(5);
      srst = 1'b0;
      wait_lvl(cpu_rst, 1'b0, 100, k);
      chk("por_len", k >= 16 && k <= 24, 1);
      chkrd(8'h8E, 8'h01, "clkctl_rst");
      chkrd(8'hD8, 8'h00, "wdctl_rst");
      chkrd(8'hE8, 8'h00, "xie_rst");
      chkrd(8'hC7, 8'h00, "ta_read");
      chkrd(8'h00, 8'h00, "unmapped");
      wr(8'h8E, 8'hC1);
      chkrd(8'h8E, 8'hC1, "clkctl_rw");
      wr(8'hE8, 8'h10);
      chkrd(8'hE8, 8'h10, "xie_rw");
      $display("test por and registers done");
   endtask : t_por

   task automatic t_lock();
      wr(8'hD8, 8'h03);
      chkrd(8'hD8, 8'h00, "lock_plain");
      wr(8'hC7, 8'hAA);
      wr(8'hC7, 8'h54);
      wr(8'hD8, 8'h03);
      chkrd(8'hD8, 8'h00, "lock_badkey");
      ul();
      wr(8'hE8, 8'h00);
      wr(8'hD8, 8'h03);
      chkrd(8'hD8, 8'h00, "lock_gap");
      ul();
      wr(8'hD8, 8'h03);
      chkrd(8'hD8, 8'h02, "unlock_en");
      ul();
      wr(8'hD8, 8'h00);
      $display("test timed access done");
   endtask : t_lock

   task automatic t_wd(input logic [1:0] c);
      int k;
      int lim;
      lim = 64 * (c + 1);
      wr(8'h8E, {c, 6'h01});
      wr(8'hE8, (c == 2'h1) ? 8'h00 : 8'h10);
      ul();
      wr(8'hD8, 8'h03);
      if (c == 2'h0)
      begin
         idle();
         cyc(40);
         ul();
         wr(8'hD8, 8'h03);
      end
      idle();
      wait_lvl(wd_irq, 1'b1, lim + 8, k);
      chk("wd_interval", (k >= lim && k <= lim + 4) || (c == 2'h1 && k == lim + 8), 1);
      chkrd(8'hD8, 8'h0A, "wd_flag");
      if (c == 2'h1)
      begin
         wr(8'hE8, 8'h10);
         idle();
         cyc(3);
      end
      chk("wd_irq", wd_irq, 1'b1);
      chk("wd_vec", {wake, vec}, 9'h163);
      if (c != 2'h3)
      begin
         ul();
         wr(8'hD8, 8'h00);
         idle();
         wait_lvl(cpu_rst, 1'b1, 600, k);
         chk("wd_disarm", k, 600);
      end
      else
      begin
         wait_lvl(cpu_rst, 1'b1, 600, k);
         chk("wd_tail", k >= 506 && k <= 512, 1);
         wait_lvl(cpu_rst, 1'b0, 20, k);
         chk("wd_pulse", k, 4);
         chkrd(8'hD8, 8'h04, "wd_cause");
         chkrd(8'h8E, 8'h01, "wd_regs");
      end
      $display("test watchdog code %0d done", c);
   endtask : t_wd

   task automatic t_pf();
      wr(8'hD8, 8'h24);
      idle();
      sup_warn = 1'b1;
      cyc(6);
      chk("pf_irq", pf_irq, 1'b1);
      chk("pf_vec", {wake, vec}, 9'h133);
      chkrd(8'hD8, 8'h34, "pf_flag");
      sup_warn = 1'b0;
      cyc(6);
      chkrd(8'hD8, 8'h34, "pf_sticky");
      wr(8'hD8, 8'h04);
      idle();
      cyc(2);
      chk("pf_clear", pf_irq, 1'b0);
      sup_warn = 1'b1;
      cyc(6);
      chk("pf_masked", pf_irq, 1'b0);
      chkrd(8'hD8, 8'h14, "pf_flag_masked");
      sup_warn = 1'b0;
      $display("test power-fail warning done");
   endtask : t_pf

   task automatic t_sup();
      int k;
      sup_rst = 1'b1;
      cyc(5);
      chk("sup_hold0", cpu_rst, 1'b1);
      cyc(40);
      chk("sup_hold1", cpu_rst, 1'b1);
      sup_rst = 1'b0;
      wait_lvl(cpu_rst, 1'b0, 100, k);
      chk("sup_release", k >= 16 && k <= 26, 1);
      chkrd(8'hD8, 8'h00, "sup_clears");
      $display("test supply reset done");
   endtask : t_sup

   // ---------------------------------------------
   // run
   // ---------------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim

   initial
   begin
      t_por();
      t_lock();
      for (int c = 0; c < 4; c++)
         t_wd(2'(c));
      t_pf();
      t_sup();
      end_sim();
   end

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      end_sim();
   end
endmodule : wdpfs_top_tb_top

`default_nettype wire
